// file: hdl/pcrw_pkg.sv
// Purpose: constants and types for the clock, reset and watchdog control.
// Assumes: clk_sys is the oscillator clock at 10 MHz; plain register port.
// Notes: register offsets are word addresses on the register port.
// Notes on behaviour
// (R1) core frequency set by F, R, OD
// (R2) software keeps R, F, OD in range
// (R3) core PLL resets to OD2 F99 R0
// (R4) software may rewrite core PLL settings
// (R5) reference divider independent of core, switch dividers
// (R6) low power mode bypasses both PLLs
// (R7) software lowers clocks before PLL frequency
// (R8) secondary PLL input select and scaling
// (R9) fractional dither uses F+1 part of period
// (R10) software keeps fraction below period
// (R11) application clock divides in even steps
// (R12) application clock to pin and tile port
// (R13) oscillator runs before reset release
// (R14) power-on reset defines every state
// (R15) pull-downs enabled while in reset
// (R16) external reset pin resets, then boot starts
// (R17) five TCK with TMS high idles TAP
// (R18) core PLL write soft-resets all but PLL
// (R19) watchdog on oscillator clock forces reset
// (R20) 12-bit count, 16-bit prescale watchdog
// (R21) clearing watchdog restarts prescaler and counter
package pcrw_pkg;

  // register word offsets
  localparam logic [15:0] CORE_PLL_OFS = 16'h0006;
  localparam logic [15:0] CLOCK_MODE_OFS = 16'h0007;
  localparam logic [15:0] APP_DIV_OFS = 16'h000E;
  localparam logic [15:0] APP_PLL_OFS = 16'h000F;
  localparam logic [15:0] APP_FRAC_OFS = 16'h0012;
  localparam logic [15:0] WD_SETUP_OFS = 16'hF020;
  localparam logic [15:0] WD_STATE_OFS = 16'hF024;

  // pll control field positions (core and secondary alike)
  localparam int R_LSB = 0;
  localparam int F_LSB = 8;
  localparam int OD_LSB = 23;
  localparam int INSEL_BIT = 28; // secondary only: 1 selects core PLL

  // clock mode register
  localparam int REFDIV_LSB = 0;
  localparam int COREDIV_LSB = 8;
  localparam int SWDIV_LSB = 16;
  localparam int BYPASS_BIT = 24;

  // application divider and fraction register
  localparam int ENABLE_BIT = 31;
  localparam int FRAC_P_LSB = 0;
  localparam int FRAC_F_LSB = 8;

  // watchdog setup and state
  localparam int WD_PRE_LSB = 0;
  localparam int WD_LIM_LSB = 16;
  localparam int WD_CLRF_BIT = 30;
  localparam int WD_EN_BIT = 31;
  localparam int WD_FIRED_BIT = 31;

  // reset values
  localparam logic [2:0] CORE_OD_RST = 3'h2;
  localparam logic [12:0] CORE_F_RST = 13'h0063;
  localparam logic [5:0] CORE_R_RST = 6'h00;
  localparam logic [7:0] REFDIV_RST = 8'h03; // 400 MHz core / 4
  localparam logic [7:0] COREDIV_RST = 8'h00;
  localparam logic [7:0] SWDIV_RST = 8'h00;

  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYC =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TAP_IDLE_EDGES = 5;

  // one pll's settings, as handed to the analog core
  typedef struct packed {
    logic [2:0] od;
    logic [12:0] f;
    logic [5:0] r;
  } pcrw_pll_s;

  // clock tree divider settings
  typedef struct packed {
    logic bypass;
    logic [7:0] switch_div;
    logic [7:0] core_div;
    logic [7:0] ref_div;
  } pcrw_clk_mode_s;

endpackage

// file: hdl/pcrw_ctrl.sv
// Purpose: digital control of core and secondary PLL, resets and watchdog.
// Assumes: clk_sys is the oscillator input; inputs are synchronous to it.
// Notes: analog PLL cores consume the settings outputs; nothing analog here.
// Notes: a watchdog reset disarms the watchdog it came from.
// Notes: a core PLL write starts a soft reset.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module pcrw_ctrl #(
  parameter int WD_PRE_W = 16, // watchdog prescale width
  parameter int WD_CNT_W = 12, // watchdog counter width
  parameter int APP_DIV_W = 16 // application divider width
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rst_ext_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic [15:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  output pcrw_pkg::pcrw_pll_s core_pll,
  output pcrw_pkg::pcrw_pll_s app_pll,
  output logic app_pll_in_core,
  output pcrw_pkg::pcrw_clk_mode_s clk_mode,
  output logic app_clock_output_pin,
  output logic app_clock_port_1d,
  output logic chip_reset_n,
  output logic soft_reset_n,
  output logic pin_pulldown_en,
  output logic boot_start,
  output logic tap_idle_reset
);

  // widths the watchdog and divider fields can carry
  if (WD_PRE_W < 1 || WD_PRE_W > 16 || WD_CNT_W < 1 || WD_CNT_W > 14
      || APP_DIV_W < 1 || APP_DIV_W > 31) begin : g_bad_param
    $error("pcrw_ctrl: unsupported parameter widths");
  end

  // counter just wide enough for the hold count
  localparam int HOLD_W = $clog2(pcrw_pkg::RESET_HOLD_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD =
    HOLD_W'(pcrw_pkg::RESET_HOLD_CYC);

  // register state
  logic [31:0] core_ctl_reg; // core pll settings word
  logic [31:0] mode_reg; // clock tree dividers and bypass
  logic [31:0] app_div_reg; // app clock divider and enable
  logic [31:0] app_pll_reg; // secondary pll settings
  logic [31:0] frac_reg; // fractional divider setup
  logic wd_en_reg; // watchdog running
  logic [WD_PRE_W-1:0] wd_pre_lim_reg; // prescale limit
  logic [WD_CNT_W-1:0] wd_cnt_lim_reg; // count limit
  logic [WD_PRE_W-1:0] wd_pre_reg; // prescale counter
  logic [WD_CNT_W-1:0] wd_cnt_reg; // main counter
  logic wd_fired_reg; // sticky: watchdog caused a reset
  logic [HOLD_W-1:0] hold_reg; // reset hold counter
  logic full_hold_reg; // current hold is a full reset
  logic in_reset_reg; // any reset phase in progress
  logic [7:0] frac_cnt_reg; // dither period counter
  logic [APP_DIV_W-1:0] app_cnt_reg; // half period counter
  logic app_clk_reg; // divided application clock
  logic tck_prev_reg; // previous tck sample
  logic [2:0] tap_cnt_reg; // tck edges seen with tms high
  logic [31:0] rd_data_reg;
  pcrw_pkg::pcrw_pll_s app_pll_reg_out;
  logic boot_start_reg;
  logic tap_idle_reg;
  logic chip_reset_n_reg;
  logic soft_reset_n_reg;
  logic pulldown_reg;

  // decoded strobes
  logic wr_core, wr_mode, wr_app_div, wr_app_pll, wr_frac, wr_wd;
  logic wd_timeout; // watchdog expiry this cycle
  logic full_req; // full chip reset request
  logic wd_tick; // prescaler wrap

  assign wr_core = wr_en && addr == pcrw_pkg::CORE_PLL_OFS;
  assign wr_mode = wr_en && addr == pcrw_pkg::CLOCK_MODE_OFS;
  assign wr_app_div = wr_en && addr == pcrw_pkg::APP_DIV_OFS;
  assign wr_app_pll = wr_en && addr == pcrw_pkg::APP_PLL_OFS;
  assign wr_frac = wr_en && addr == pcrw_pkg::APP_FRAC_OFS;
  assign wr_wd = wr_en && addr == pcrw_pkg::WD_SETUP_OFS;

  // counter steps once per prescale period, so the
  // time-out is (pre+1)*(lim+1) clocks
  assign wd_tick = wd_pre_reg == wd_pre_lim_reg;
  assign wd_timeout = wd_en_reg && wd_tick
                      && wd_cnt_reg == wd_cnt_lim_reg; // R19 R20
  // pin and watchdog share the full reset path
  assign full_req = !rst_ext_n || wd_timeout; // R16 R19

  // core pll settings; a full reset restores the boot ratio
  // a soft reset deliberately leaves them alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_ctl_reg <= '0; // R14
      core_ctl_reg[pcrw_pkg::OD_LSB +: 3] <= pcrw_pkg::CORE_OD_RST; // R3
      core_ctl_reg[pcrw_pkg::F_LSB +: 13] <= pcrw_pkg::CORE_F_RST; // R3
      core_ctl_reg[pcrw_pkg::R_LSB +: 6] <= pcrw_pkg::CORE_R_RST; // R3
    end else if (full_req) begin
      core_ctl_reg <= '0;
      core_ctl_reg[pcrw_pkg::OD_LSB +: 3] <= pcrw_pkg::CORE_OD_RST; // R3
      core_ctl_reg[pcrw_pkg::F_LSB +: 13] <= pcrw_pkg::CORE_F_RST;
      core_ctl_reg[pcrw_pkg::R_LSB +: 6] <= pcrw_pkg::CORE_R_RST;
    end else if (wr_core) begin
      // fields are not range checked
      core_ctl_reg <= wr_data; // R4 R18
    end
  end

  // clock tree mode and secondary pll; pll logic survives soft reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= '0;
      mode_reg[pcrw_pkg::REFDIV_LSB +: 8] <= pcrw_pkg::REFDIV_RST;
      mode_reg[pcrw_pkg::COREDIV_LSB +: 8] <= pcrw_pkg::COREDIV_RST;
      mode_reg[pcrw_pkg::SWDIV_LSB +: 8] <= pcrw_pkg::SWDIV_RST;
      app_div_reg <= '0;
      app_pll_reg <= '0;
      frac_reg <= '0;
    end else if (full_req) begin
      mode_reg <= '0;
      mode_reg[pcrw_pkg::REFDIV_LSB +: 8] <= pcrw_pkg::REFDIV_RST;
      mode_reg[pcrw_pkg::COREDIV_LSB +: 8] <= pcrw_pkg::COREDIV_RST;
      mode_reg[pcrw_pkg::SWDIV_LSB +: 8] <= pcrw_pkg::SWDIV_RST;
      app_div_reg <= '0;
      app_pll_reg <= '0;
      frac_reg <= '0;
    end else begin
      if (wr_mode) begin
        // bypass acts through the clock tree mux
        mode_reg <= wr_data; // R5 R6
      end
      if (wr_app_div) begin
        app_div_reg <= wr_data; // R11
      end
      if (wr_app_pll) begin
        app_pll_reg <= wr_data; // R8
      end
      if (wr_frac) begin
        frac_reg <= wr_data; // R9
      end
    end
  end

  // watchdog: any setup write restarts both stages from zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_en_reg <= 1'b0;
      wd_pre_lim_reg <= '0;
      wd_cnt_lim_reg <= '0;
      wd_pre_reg <= '0;
      wd_cnt_reg <= '0;
    end else if (full_req || in_reset_reg) begin
      // disarmed so a fired watchdog cannot loop the chip in reset
      wd_en_reg <= 1'b0;
      wd_pre_reg <= '0;
      wd_cnt_reg <= '0;
    end else if (wr_wd) begin
      // setup writes in a reset phase never get here
      wd_en_reg <= wr_data[pcrw_pkg::WD_EN_BIT];
      wd_pre_lim_reg <= wr_data[pcrw_pkg::WD_PRE_LSB +: WD_PRE_W]; // R20
      wd_cnt_lim_reg <= wr_data[pcrw_pkg::WD_LIM_LSB +: WD_CNT_W]; // R20
      wd_pre_reg <= '0; // R21
      wd_cnt_reg <= '0; // R21
    end else if (wd_en_reg) begin
      wd_pre_reg <= wd_tick ? '0 : wd_pre_reg + 1'b1; // R19
      if (wd_tick) begin
        wd_cnt_reg <= wd_cnt_reg + 1'b1; // R20
      end
    end
  end

  // fired flag: set wins over the software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wd_fired_reg <= 1'b0;
    end else if (wd_timeout) begin
      wd_fired_reg <= 1'b1; // R19
      // only power-on clears it without software
    end else if (wr_wd && wr_data[pcrw_pkg::WD_CLRF_BIT]) begin
      wd_fired_reg <= 1'b0;
    end
  end

  // reset sequencer: full or soft requests hold the reset for a while
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= HOLD_LOAD; // R14
      full_hold_reg <= 1'b1;
      in_reset_reg <= 1'b1;
    end else if (full_req) begin
      hold_reg <= HOLD_LOAD; // R16 R19
      full_hold_reg <= 1'b1;
      in_reset_reg <= 1'b1;
    end else if (wr_core) begin
      hold_reg <= HOLD_LOAD; // R18
      // a soft request inside a full reset stays full
      full_hold_reg <= full_hold_reg && in_reset_reg;
      in_reset_reg <= 1'b1;
    end else if (hold_reg != '0) begin
      // outputs stay in reset for the whole count
      hold_reg <= hold_reg - 1'b1;
    end else begin
      in_reset_reg <= 1'b0;
      full_hold_reg <= 1'b0;
    end
  end

  // reset outputs, pull-downs and the boot start pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_n_reg <= 1'b0; // R14
      soft_reset_n_reg <= 1'b0;
      pulldown_reg <= 1'b1; // R15
      boot_start_reg <= 1'b0;
    end else begin
      chip_reset_n_reg <= !(in_reset_reg && full_hold_reg);
      soft_reset_n_reg <= !in_reset_reg; // R18
      pulldown_reg <= in_reset_reg; // R15
      // boot pulses on the edge the reset outputs release:
      // soft_reset_n still low marks the last reset cycle
      boot_start_reg <= !soft_reset_n_reg && !in_reset_reg; // R16
    end
  end

  // fractional dither: F+1 for f+1 of every p+1 clocks
  // only meaningful while f < p; other settings still divide sanely
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frac_cnt_reg <= '0;
    end else if (!frac_reg[pcrw_pkg::ENABLE_BIT] || wr_frac) begin
      // new settings start a fresh period
      frac_cnt_reg <= '0;
    end else if (frac_cnt_reg >= frac_reg[pcrw_pkg::FRAC_P_LSB +: 8]) begin
      frac_cnt_reg <= '0; // R9
    end else begin
      frac_cnt_reg <= frac_cnt_reg + 1'b1; // R9
    end
  end

  // secondary pll settings with the dither step folded into F
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      app_pll_reg_out <= '0;
    end else begin
      // only f carries the dither step
      app_pll_reg_out.od <= app_pll_reg[pcrw_pkg::OD_LSB +: 3]; // R8
      app_pll_reg_out.r <= app_pll_reg[pcrw_pkg::R_LSB +: 6]; // R8
      if (frac_reg[pcrw_pkg::ENABLE_BIT]
          && frac_cnt_reg <= frac_reg[pcrw_pkg::FRAC_F_LSB +: 8]) begin
        app_pll_reg_out.f <= app_pll_reg[pcrw_pkg::F_LSB +: 13]
                             + 13'h0001; // R9
      end else begin
        app_pll_reg_out.f <= app_pll_reg[pcrw_pkg::F_LSB +: 13]; // R8
      end
    end
  end

  // application clock: toggle every div+1 clocks, so only even ratios
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      app_cnt_reg <= '0;
      app_clk_reg <= 1'b0;
    end else if (!app_div_reg[pcrw_pkg::ENABLE_BIT] || wr_app_div) begin
      // a rewrite restarts low; a short half may result
      app_cnt_reg <= '0; // held low while disabled
      app_clk_reg <= 1'b0;
    end else if (app_cnt_reg == app_div_reg[APP_DIV_W-1:0]) begin
      app_cnt_reg <= '0;
      app_clk_reg <= !app_clk_reg; // R11
    end else begin
      app_cnt_reg <= app_cnt_reg + 1'b1;
    end
  end

  // tap idle: count tck rising edges while tms stays high
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tck_prev_reg <= 1'b0;
      tap_cnt_reg <= '0;
      tap_idle_reg <= 1'b0;
    end else begin
      // tck is sampled as a level, so it must run
      // well below half of clk_sys
      tck_prev_reg <= tck;
      tap_idle_reg <= 1'b0;
      if (!tms) begin
        tap_cnt_reg <= '0;
      end else if (tck && !tck_prev_reg) begin
        if (tap_cnt_reg == 3'(pcrw_pkg::TAP_IDLE_EDGES - 1)) begin
          tap_cnt_reg <= '0;
          tap_idle_reg <= 1'b1; // R17
        end else begin
          tap_cnt_reg <= tap_cnt_reg + 1'b1; // R17
        end
      end
    end
  end

  // registered read mux; unmapped words read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= '0;
    end else if (rd_en) begin
      rd_data_reg <= '0;
      unique case (addr)
        pcrw_pkg::CORE_PLL_OFS: rd_data_reg <= core_ctl_reg;
        pcrw_pkg::CLOCK_MODE_OFS: rd_data_reg <= mode_reg;
        pcrw_pkg::APP_DIV_OFS: rd_data_reg <= app_div_reg;
        pcrw_pkg::APP_PLL_OFS: rd_data_reg <= app_pll_reg;
        pcrw_pkg::APP_FRAC_OFS: rd_data_reg <= frac_reg;
        // clear bit reads back as zero
        pcrw_pkg::WD_SETUP_OFS: begin
          rd_data_reg[pcrw_pkg::WD_EN_BIT] <= wd_en_reg;
          rd_data_reg[pcrw_pkg::WD_PRE_LSB +: WD_PRE_W] <= wd_pre_lim_reg;
          rd_data_reg[pcrw_pkg::WD_LIM_LSB +: WD_CNT_W] <= wd_cnt_lim_reg;
        end
        // live counts, stale by the time they are used
        pcrw_pkg::WD_STATE_OFS: begin
          rd_data_reg[pcrw_pkg::WD_FIRED_BIT] <= wd_fired_reg;
          rd_data_reg[pcrw_pkg::WD_LIM_LSB +: WD_CNT_W] <= wd_cnt_reg;
          rd_data_reg[pcrw_pkg::WD_PRE_LSB +: WD_PRE_W] <= wd_pre_reg;
        end
        default: rd_data_reg <= '0;
      endcase
    end else begin
      rd_data_reg <= '0;
    end
  end

  // settings outputs, all straight from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_pll <= '{od: pcrw_pkg::CORE_OD_RST, f: pcrw_pkg::CORE_F_RST,
                    r: pcrw_pkg::CORE_R_RST}; // R3
      app_pll_in_core <= 1'b0;
      // tree dividers match the mode register's reset word
      clk_mode <= '{bypass: 1'b0, switch_div: pcrw_pkg::SWDIV_RST,
                    core_div: pcrw_pkg::COREDIV_RST,
                    ref_div: pcrw_pkg::REFDIV_RST}; // R14
      app_clock_output_pin <= 1'b0;
      app_clock_port_1d <= 1'b0;
    end else begin
      core_pll.od <= core_ctl_reg[pcrw_pkg::OD_LSB +: 3]; // R1
      core_pll.f <= core_ctl_reg[pcrw_pkg::F_LSB +: 13]; // R1
      core_pll.r <= core_ctl_reg[pcrw_pkg::R_LSB +: 6]; // R1
      app_pll_in_core <= app_pll_reg[pcrw_pkg::INSEL_BIT]; // R8
      clk_mode.ref_div <= mode_reg[pcrw_pkg::REFDIV_LSB +: 8]; // R5
      clk_mode.core_div <= mode_reg[pcrw_pkg::COREDIV_LSB +: 8]; // R5
      clk_mode.switch_div <= mode_reg[pcrw_pkg::SWDIV_LSB +: 8]; // R5
      clk_mode.bypass <= mode_reg[pcrw_pkg::BYPASS_BIT]; // R6
      // both copies from one source, so they match
      app_clock_output_pin <= app_clk_reg; // R12
      app_clock_port_1d <= app_clk_reg; // R12
    end
  end

  // ports straight from their flops
  assign rd_data = rd_data_reg;
  assign app_pll = app_pll_reg_out;
  assign chip_reset_n = chip_reset_n_reg;
  assign soft_reset_n = soft_reset_n_reg;
  assign pin_pulldown_en = pulldown_reg;
  assign boot_start = boot_start_reg;
  assign tap_idle_reset = tap_idle_reg;

endmodule // pcrw_ctrl
`default_nettype wire

// file: test/pcrw_ctrl_monitor.sv
// Purpose: port-level checks of the clock, reset and watchdog control.
// Assumes: one clock domain, clk_sys, with async active-low rst_n.
// Notes: bound into every pcrw_ctrl instance at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module pcrw_ctrl_monitor #(
  parameter int WD_PRE_W = 16,
  parameter int WD_CNT_W = 12,
  parameter int APP_DIV_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rst_ext_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic [15:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire pcrw_pkg::pcrw_pll_s core_pll,
  input wire pcrw_pkg::pcrw_pll_s app_pll,
  input wire logic app_pll_in_core,
  input wire pcrw_pkg::pcrw_clk_mode_s clk_mode,
  input wire logic app_clock_output_pin,
  input wire logic app_clock_port_1d,
  input wire logic chip_reset_n,
  input wire logic soft_reset_n,
  input wire logic pin_pulldown_en,
  input wire logic boot_start,
  input wire logic tap_idle_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // core pll write that the external reset does not override
  logic core_wr;
  assign core_wr = wr_en && addr == pcrw_pkg::CORE_PLL_OFS && rst_ext_n;
  // boot pulse lasts exactly one cycle
  sequence s_boot_pulse;
    boot_start ##1 !boot_start;
  endsequence
  // soft reset entered while the chip itself stays out of reset
  sequence s_soft_only;
    ##[1:2] (!soft_reset_n && chip_reset_n);
  endsequence
  property p_ext_pll;
    !rst_ext_n |=> ##1 core_pll == {3'h2, 13'h0063, 6'h00};
  endproperty
  a_ext_pll: assert property (p_ext_pll)
    else $error("core pll not at start values in reset");
  property p_ext_chip;
    !rst_ext_n |=> ##1 !chip_reset_n && !soft_reset_n && pin_pulldown_en;
  endproperty
  a_ext_chip: assert property (p_ext_chip)
    else $error("external reset did not reset the chip");
  property p_pulldown;
    !chip_reset_n |-> pin_pulldown_en;
  endproperty
  a_pulldown: assert property (p_pulldown)
    else $error("pull-downs off while in reset");
  property p_boot;
    $rose(chip_reset_n) |-> s_boot_pulse;
  endproperty
  a_boot: assert property (p_boot)
    else $error("no single boot pulse on leaving reset");
  property p_soft;
    core_wr && chip_reset_n |-> s_soft_only;
  endproperty
  a_soft: assert property (p_soft)
    else $error("core pll write did not soft reset");
  property p_pll_take;
    core_wr |=> ##1 core_pll == {$past(wr_data[25:23], 2),
      $past(wr_data[20:8], 2), $past(wr_data[5:0], 2)};
  endproperty
  a_pll_take: assert property (p_pll_take)
    else $error("core pll settings not taken");
  property p_pll_keep;
    !soft_reset_n && chip_reset_n && rst_ext_n && !core_wr |=>
      $stable(core_pll);
  endproperty
  a_pll_keep: assert property (p_pll_keep)
    else $error("core pll changed during soft reset");
  property p_mode;
    wr_en && addr == pcrw_pkg::CLOCK_MODE_OFS && rst_ext_n |=>
      ##1 clk_mode == $past(wr_data[24:0], 2);
  endproperty
  a_mode: assert property (p_mode)
    else $error("clock mode not taken");
  property p_insel;
    wr_en && addr == pcrw_pkg::APP_PLL_OFS && rst_ext_n |=> ##1
      app_pll_in_core == $past(wr_data[28], 2)
      && app_pll.r == $past(wr_data[5:0], 2);
  endproperty
  a_insel: assert property (p_insel)
    else $error("secondary pll settings not taken");
  property p_tap;
    tap_idle_reset |-> $past(tms) ##1 !tap_idle_reset;
  endproperty
  a_tap: assert property (p_tap)
    else $error("tap idle pulse malformed");
  property p_pin;
    app_clock_output_pin == app_clock_port_1d;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin and tile port clocks differ");
endmodule // pcrw_ctrl_monitor
bind pcrw_ctrl pcrw_ctrl_monitor #(.WD_PRE_W(WD_PRE_W), .WD_CNT_W(WD_CNT_W),
  .APP_DIV_W(APP_DIV_W)) u_pcrw_ctrl_monitor (.clk_sys(clk_sys),
  .rst_n(rst_n), .rst_ext_n(rst_ext_n), .tck(tck), .tms(tms), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .core_pll(core_pll), .app_pll(app_pll), .app_pll_in_core(app_pll_in_core),
  .clk_mode(clk_mode), .app_clock_output_pin(app_clock_output_pin),
  .app_clock_port_1d(app_clock_port_1d), .chip_reset_n(chip_reset_n),
  .soft_reset_n(soft_reset_n), .pin_pulldown_en(pin_pulldown_en),
  .boot_start(boot_start), .tap_idle_reset(tap_idle_reset));
`default_nettype wire

// file: test/tb_top.sv
// Purpose: self-checking bench for the clock, reset and watchdog control.
// Assumes: register port with one-cycle strobes, read data one cycle later.
// Notes: every wait is bounded; a spent wait_hi bound ends the run as a failure.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic rst_ext_n = 1'b1;
  logic tck = 1'b0;
  logic tms = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] wr_data = 32'h00000000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [31:0] rd_data;
  pcrw_pkg::pcrw_pll_s core_pll;
  pcrw_pkg::pcrw_pll_s app_pll;
  pcrw_pkg::pcrw_clk_mode_s clk_mode;
  logic app_pll_in_core, app_clock_output_pin, app_clock_port_1d;
  logic chip_reset_n, soft_reset_n, pin_pulldown_en, boot_start;
  logic tap_idle_reset;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] d;
  int n;
  int m;
  // 10 MHz oscillator clock
  always #50 clk_sys = ~clk_sys;
  pcrw_ctrl u_pcrw_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .rst_ext_n(rst_ext_n), .tck(tck), .tms(tms), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .core_pll(core_pll), .app_pll(app_pll), .app_pll_in_core(app_pll_in_core),
    .clk_mode(clk_mode), .app_clock_output_pin(app_clock_output_pin),
    .app_clock_port_1d(app_clock_port_1d), .chip_reset_n(chip_reset_n),
    .soft_reset_n(soft_reset_n), .pin_pulldown_en(pin_pulldown_en),
    .boot_start(boot_start), .tap_idle_reset(tap_idle_reset));
  // closing report, the single place the run ends
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // step k edges, then sample just after the last one
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    v = rd_data;
  endtask
  // condition picker for the bounded wait
  function automatic logic sel(input int w);
    case (w)
      0: return chip_reset_n;
      1: return soft_reset_n;
      2: return boot_start;
      3: return ~soft_reset_n;
      default: return ~chip_reset_n;
    endcase
  endfunction
  task automatic wait_hi(input int w);
    int i;
    for (i = 0; i < 60; i++) begin
      cyc(1);
      if (sel(w) === 1'b1)
        break;
    end
    if (sel(w) !== 1'b1) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, 1'b0, 1'b1);
      results();
    end
  endtask
  // cycles until the application clock next changes, at most 20
  task automatic half(output int k);
    logic v;
    v = app_clock_output_pin;
    for (k = 1; k < 20; k++) begin
      cyc(1);
      if (app_clock_output_pin !== v)
        break;
    end
  endtask
  // k test clock rises at mode level m, counting idle pulses
  task automatic tk(input logic m, input int k, output int p);
    int j;
    p = 0;
    for (j = 0; j < 4 * k + 4; j++) begin
      @(posedge clk_sys);
      tms <= m;
      tck <= (j < 4 * k) && (j % 4 < 2);
      #1;
      if (tap_idle_reset === 1'b1)
        p++;
    end
  endtask
  task automatic t_reset();
    #1;
    `CHK(core_pll, {3'h2, 13'h0063, 6'h00})
    `CHK(clk_mode.ref_div, 8'h03)
    `CHK({chip_reset_n, pin_pulldown_en}, 2'h1)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_hi(2);
    `CHK({chip_reset_n, soft_reset_n, pin_pulldown_en}, 3'h6)
    rd(pcrw_pkg::CORE_PLL_OFS, d);
    `CHK(d, 32'h01006300)
    rd(16'h0100, d);
    `CHK(d, 32'h00000000)
  endtask
  task automatic t_core();
    wr(pcrw_pkg::CLOCK_MODE_OFS, 32'h01020504);
    wr(pcrw_pkg::CORE_PLL_OFS, 32'h0080C701);
    wait_hi(3);
    `CHK(chip_reset_n, 1'b1)
    `CHK(core_pll, {3'h1, 13'h00C7, 6'h01})
    wait_hi(1);
    `CHK(core_pll, {3'h1, 13'h00C7, 6'h01})
    `CHK(clk_mode, {1'b1, 8'h02, 8'h05, 8'h04})
    rd(pcrw_pkg::CORE_PLL_OFS, d);
    `CHK(d, 32'h0080C701)
  endtask
  // both input selections, then fractional dither over two periods
  task automatic t_app();
    int s;
    for (s = 1; s >= 0; s--) begin
      wr(pcrw_pkg::APP_PLL_OFS,
        {3'h0, s[0], 5'h01, 2'h0, 13'h000A, 2'h0, 6'h02});
      cyc(1);
      `CHK(app_pll, {3'h1, 13'h000A, 6'h02})
      `CHK(app_pll_in_core, s[0])
    end
    wr(pcrw_pkg::APP_FRAC_OFS, 32'h80000103);
    cyc(4);
    n = 0;
    m = 0;
    repeat (8) begin
      cyc(1);
      if (app_pll.f === 13'h000B)
        n++;
      else if (app_pll.f === 13'h000A)
        m++;
    end
    `CHK({n[7:0], m[7:0]}, 16'h0404)
    wr(pcrw_pkg::APP_FRAC_OFS, 32'h00000000);
    cyc(2);
    `CHK(app_pll.f, 13'h000A)
  endtask
  task automatic t_clk();
    wr(pcrw_pkg::APP_DIV_OFS, 32'h80000002);
    half(n);
    half(n);
    `CHK(n, 3)
    half(n);
    `CHK(n, 3)
    `CHK(app_clock_port_1d, app_clock_output_pin)
    wr(pcrw_pkg::APP_DIV_OFS, 32'h00000000);
    cyc(2);
    `CHK(app_clock_output_pin, 1'b0)
  endtask
  task automatic t_tap();
    tk(1'b1, 4, n);
    `CHK(n, 0)
    tk(1'b0, 1, n);
    tk(1'b1, 4, m);
    `CHK(n + m, 0)
    tk(1'b1, 1, n);
    `CHK(n, 1)
  endtask
  task automatic t_ext();
    @(posedge clk_sys);
    rst_ext_n <= 1'b0;
    cyc(3);
    `CHK(core_pll, {3'h2, 13'h0063, 6'h00})
    `CHK(clk_mode.ref_div, 8'h03)
    `CHK({chip_reset_n, pin_pulldown_en}, 2'h1)
    @(posedge clk_sys);
    rst_ext_n <= 1'b1;
    wait_hi(2);
    `CHK(chip_reset_n, 1'b1)
  endtask
  // restart before expiry, then let a 2 x 3 cycle time-out run out
  task automatic t_wd();
    wr(pcrw_pkg::WD_SETUP_OFS, 32'h80020001);
    cyc(3);
    wr(pcrw_pkg::WD_SETUP_OFS, 32'h80020001);
    cyc(4);
    `CHK(chip_reset_n, 1'b1)
    for (n = 0; n < 6 && chip_reset_n !== 1'b0; n++)
      cyc(1);
    `CHK(chip_reset_n, 1'b0)
    wait_hi(0);
    rd(pcrw_pkg::WD_STATE_OFS, d);
    `CHK(d[31], 1'b1)
    wr(pcrw_pkg::WD_SETUP_OFS, 32'h40000000);
    rd(pcrw_pkg::WD_STATE_OFS, d);
    `CHK(d[31], 1'b0)
    cyc(20);
    `CHK(chip_reset_n, 1'b1)
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    t_reset();
    t_core();
    t_app();
    t_clk();
    t_tap();
    t_ext();
    t_wd();
    results();
  end
endmodule // tb_top
`default_nettype wire
